// ==== upt_pkg.sv ====
package upt_pkg;

	// ****************************************************
	// Field encodings
	// ****************************************************
	localparam logic [1:0] SPEED_HS     = 2'h0;
	localparam logic [1:0] SPEED_FS     = 2'h1;
	localparam logic [1:0] SPEED_LS     = 2'h2;
	localparam logic [1:0] SPEED_PRE    = 2'h3;
	localparam logic [1:0] MODE_NORMAL  = 2'h0;
	localparam logic [1:0] MODE_RESUME  = 2'h2;
	localparam logic [1:0] LINE_SE0     = 2'h0;
	localparam logic [1:0] LINE_J       = 2'h1;
	localparam logic [1:0] LINE_K       = 2'h2;

	// ****************************************************
	// Pipeline delays in interface clock cycles
	// ****************************************************
	localparam logic [7:0] DLY_RXCMD_JK     = 8'h04;
	localparam logic [7:0] DLY_RXCMD_SE0_HS = 8'h04;
	localparam logic [7:0] DLY_RXCMD_SE0_FS = 8'h04;
	localparam logic [7:0] DLY_RXCMD_SE0_LS = 8'h10;
	localparam logic [7:0] DLY_TX_START_HS  = 8'h01;
	localparam logic [7:0] DLY_TX_START_FS  = 8'h06;
	localparam logic [7:0] DLY_TX_START_LS  = 8'h4A;
	localparam logic [7:0] DLY_TX_END_PKT   = 8'h03;
	localparam logic [7:0] DLY_TX_END_SOF   = 8'h06;
	localparam logic [7:0] DLY_RX_START_HS  = 8'h05;
	localparam logic [7:0] DLY_RX_START_FL  = 8'h01;
	localparam logic [7:0] DLY_RX_END_HS    = 8'h05;
	localparam logic [7:0] DLY_RX_END_FS    = 8'h11;
	localparam logic [7:0] DLY_RX_END_LS    = 8'h7A;

	// ****************************************************
	// Preamble and end-of-packet bit counts
	// ****************************************************
	localparam logic [4:0] PRE_HDR_BITS  = 5'h10;
	localparam logic [4:0] PRE_GAP_BITS  = 5'h04;
	localparam logic [1:0] EOP_SE0_BITS  = 2'h2;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h4;
	localparam logic [7:0] CTRL_RESET    = 8'h31;
	localparam int         CTRL_SPEED    = 0;
	localparam int         CTRL_MODE     = 2;
	localparam int         CTRL_TERM     = 4;
	localparam int         CTRL_LPN      = 5;
	localparam int         CTRL_DP_PD    = 6;
	localparam int         CTRL_DM_PD    = 7;

	typedef enum logic [3:0] {
		UPT_TX_IDLE,
		UPT_TX_START,
		UPT_TX_PRE_HDR,
		UPT_TX_PRE_J,
		UPT_TX_PRE_GAP,
		UPT_TX_SEND,
		UPT_TX_END,
		UPT_TX_RESUME,
		UPT_TX_EOP_SE0,
		UPT_TX_EOP_J
	} upt_tx_state_type;

endpackage

// ==== upt_delay.sv ====
module upt_delay (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       load,
	input  wire logic [7:0] count_val,
	output logic            busy,
	output logic            done
);

	logic [7:0] count;

	// Counted in interface clocks from the edge where load is sampled
	assign done = busy && (count == 8'h00);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy  <= 1'b0;
			count <= 8'h00;
		end else if (load) begin
			busy  <= 1'b1;
			count <= count_val - 8'h01;
		end else if (done) begin
			busy  <= 1'b0;
		end else if (busy) begin
			count <= count - 8'h01;
		end
	end

endmodule

// ==== upt_timing.sv ====
// Strobed register access and the register addresses were left to the implementer.
module upt_timing (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       tx_cmd,
	input  wire logic       tx_sof,
	input  wire logic       stp,
	input  wire logic       rx_sync_raw,
	input  wire logic [1:0] line_state_raw,
	input  wire logic       ls_bit_clk,
	output logic            rxcmd_valid,
	output logic      [1:0] rxcmd_line_state,
	output logic            receive_in_progress,
	output logic            tx_bus_active,
	output logic            pre_header,
	output logic            ls_bit_rate,
	output logic            fs_edge_rate,
	output logic      [1:0] drive_state,
	output logic            drive_oe_n,
	output logic      [1:0] speed_select_field,
	output logic            termination_select_bit,
	output logic            active_low_low_power_bit
);

	// ****************************************************
	// Delay selection
	// ****************************************************
	function automatic logic [7:0] rxcmd_delay(input logic [1:0] speed, input logic se0);
		logic [7:0] d;
		d = upt_pkg::DLY_RXCMD_JK;
		if (se0) begin
			unique case (speed)
				upt_pkg::SPEED_HS: d = upt_pkg::DLY_RXCMD_SE0_HS;
				upt_pkg::SPEED_LS: d = upt_pkg::DLY_RXCMD_SE0_LS;
				default:           d = upt_pkg::DLY_RXCMD_SE0_FS;
			endcase
		end
		return d;
	endfunction

	function automatic logic [7:0] tx_start_delay(input logic [1:0] speed);
		logic [7:0] d;
		unique case (speed)
			upt_pkg::SPEED_HS: d = upt_pkg::DLY_TX_START_HS;
			upt_pkg::SPEED_LS: d = upt_pkg::DLY_TX_START_LS;
			default:           d = upt_pkg::DLY_TX_START_FS;
		endcase
		return d;
	endfunction

	// Preamble receive carries low-speed packets, so it takes the low-speed end delay
	function automatic logic [7:0] rx_end_delay(input logic [1:0] speed);
		logic [7:0] d;
		unique case (speed)
			upt_pkg::SPEED_HS: d = upt_pkg::DLY_RX_END_HS;
			upt_pkg::SPEED_FS: d = upt_pkg::DLY_RX_END_FS;
			default:           d = upt_pkg::DLY_RX_END_LS;
		endcase
		return d;
	endfunction

	// ****************************************************
	// Control register and read port
	// ****************************************************
	logic [7:0] ctrl;
	logic [1:0] speed;
	logic [1:0] mode;
	logic       host_role;
	logic       is_hs;
	logic       is_pre;
	logic [7:0] status;
	logic [7:0] rd_mux;

	assign speed     = ctrl[upt_pkg::CTRL_SPEED +: 2];
	assign mode      = ctrl[upt_pkg::CTRL_MODE +: 2];
	assign host_role = ctrl[upt_pkg::CTRL_DP_PD] && ctrl[upt_pkg::CTRL_DM_PD];
	assign is_hs     = (speed == upt_pkg::SPEED_HS);
	assign is_pre    = (speed == upt_pkg::SPEED_PRE);

	assign speed_select_field       = speed;
	assign termination_select_bit   = ctrl[upt_pkg::CTRL_TERM];
	assign active_low_low_power_bit = ctrl[upt_pkg::CTRL_LPN];
	assign fs_edge_rate             = (speed != upt_pkg::SPEED_HS) && (speed != upt_pkg::SPEED_LS);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= upt_pkg::CTRL_RESET;
		end else if (reg_wr && (reg_addr == upt_pkg::REG_CTRL)) begin
			ctrl <= reg_wdata;
		end
	end

	assign rd_mux = (reg_addr == upt_pkg::REG_CTRL)   ? ctrl :
	                (reg_addr == upt_pkg::REG_STATUS) ? status : 8'h00;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ****************************************************
	// Synchronisers for the analogue side
	// ****************************************************
	logic [1:0] line_s1;
	logic [1:0] line_sync;
	logic [1:0] line_prev;
	logic       rx_s1;
	logic       rx_sync;
	logic       rx_prev;
	logic       bit_s1;
	logic       bit_sync;
	logic       bit_prev;
	logic       line_chg;
	logic       line_se0;
	logic       rx_rise;
	logic       rx_fall;
	logic       bit_tick;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_s1   <= upt_pkg::LINE_J;
			line_sync <= upt_pkg::LINE_J;
			line_prev <= upt_pkg::LINE_J;
			rx_s1     <= 1'b0;
			rx_sync   <= 1'b0;
			rx_prev   <= 1'b0;
			bit_s1    <= 1'b0;
			bit_sync  <= 1'b0;
			bit_prev  <= 1'b0;
		end else begin
			line_s1   <= line_state_raw;
			line_sync <= line_s1;
			line_prev <= line_sync;
			rx_s1     <= rx_sync_raw;
			rx_sync   <= rx_s1;
			rx_prev   <= rx_sync;
			bit_s1    <= ls_bit_clk;
			bit_sync  <= bit_s1;
			bit_prev  <= bit_sync;
		end
	end

	assign line_chg = (line_sync != line_prev);
	assign line_se0 = (line_sync == upt_pkg::LINE_SE0);
	assign rx_rise  = rx_sync && !rx_prev;
	assign rx_fall  = !rx_sync && rx_prev;
	assign bit_tick = bit_sync && !bit_prev;

	// ****************************************************
	// Receive command and receive framing
	// ****************************************************
	logic       rxcmd_done;
	logic       rx_done;
	logic       rx_end_pending;
	logic [7:0] rx_load_val;

	// A new change restarts the delay, so only the latest level is reported
	upt_delay u_rxcmd_dly (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.load      (line_chg),
		.count_val (rxcmd_delay(speed, line_se0)),
		.busy      (),
		.done      (rxcmd_done)
	);

	assign rxcmd_valid = rxcmd_done;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxcmd_line_state <= upt_pkg::LINE_J;
		end else if (line_chg) begin
			rxcmd_line_state <= line_sync;
		end
	end

	// Start delay applies at high speed only; other speeds flag the start next clock
	assign rx_load_val = rx_fall ? rx_end_delay(speed) :
	                     (is_hs ? upt_pkg::DLY_RX_START_HS : upt_pkg::DLY_RX_START_FL);

	upt_delay u_rx_dly (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.load      (rx_rise || rx_fall),
		.count_val (rx_load_val),
		.busy      (),
		.done      (rx_done)
	);

	// Low-speed traffic on the full-speed bus is framed the same way in preamble mode
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_end_pending      <= 1'b0;
			receive_in_progress <= 1'b0;
		end else begin
			if (rx_rise || rx_fall) begin
				rx_end_pending <= rx_fall;
			end
			if (rx_done) begin
				receive_in_progress <= !rx_end_pending;
			end
		end
	end

	// ****************************************************
	// Transmit sequencing
	// ****************************************************
	upt_pkg::upt_tx_state_type tx_state;
	upt_pkg::upt_tx_state_type next_tx_state;
	logic       tx_done;
	logic       tx_load;
	logic [7:0] tx_load_val;
	logic       sof_held;
	logic [4:0] pre_cnt;
	logic [1:0] eop_cnt;

	assign tx_load = ((tx_state == upt_pkg::UPT_TX_IDLE) && tx_cmd && (mode != upt_pkg::MODE_RESUME)) ||
	                 ((tx_state == upt_pkg::UPT_TX_SEND) && stp && is_hs);
	assign tx_load_val = (tx_state == upt_pkg::UPT_TX_SEND) ?
	                     (sof_held ? upt_pkg::DLY_TX_END_SOF : upt_pkg::DLY_TX_END_PKT) :
	                     tx_start_delay(speed);

	upt_delay u_tx_dly (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.load      (tx_load),
		.count_val (tx_load_val),
		.busy      (),
		.done      (tx_done)
	);

	always_comb begin
		next_tx_state = tx_state;
		unique case (tx_state)
			upt_pkg::UPT_TX_IDLE: begin
				if (tx_cmd) begin
					next_tx_state = (mode == upt_pkg::MODE_RESUME) ? upt_pkg::UPT_TX_RESUME : upt_pkg::UPT_TX_START;
				end
			end
			upt_pkg::UPT_TX_START: begin
				if (tx_done) begin
					next_tx_state = is_pre ? upt_pkg::UPT_TX_PRE_HDR : upt_pkg::UPT_TX_SEND;
				end
			end
			upt_pkg::UPT_TX_PRE_HDR: begin
				if (pre_cnt == 5'h00) begin
					next_tx_state = upt_pkg::UPT_TX_PRE_J;
				end
			end
			upt_pkg::UPT_TX_PRE_J: begin
				next_tx_state = upt_pkg::UPT_TX_PRE_GAP;
			end
			upt_pkg::UPT_TX_PRE_GAP: begin
				if (pre_cnt == 5'h00) begin
					next_tx_state = upt_pkg::UPT_TX_SEND;
				end
			end
			upt_pkg::UPT_TX_SEND: begin
				if (stp) begin
					// End delay exists only at high speed
					next_tx_state = is_hs ? upt_pkg::UPT_TX_END : upt_pkg::UPT_TX_IDLE;
				end
			end
			upt_pkg::UPT_TX_END: begin
				if (tx_done) begin
					next_tx_state = upt_pkg::UPT_TX_IDLE;
				end
			end
			upt_pkg::UPT_TX_RESUME: begin
				if (stp) begin
					next_tx_state = host_role ? upt_pkg::UPT_TX_EOP_SE0 : upt_pkg::UPT_TX_IDLE;
				end
			end
			upt_pkg::UPT_TX_EOP_SE0: begin
				if (bit_tick && (eop_cnt == 2'h1)) begin
					next_tx_state = upt_pkg::UPT_TX_EOP_J;
				end
			end
			upt_pkg::UPT_TX_EOP_J: begin
				if (bit_tick) begin
					next_tx_state = upt_pkg::UPT_TX_IDLE;
				end
			end
			default: next_tx_state = upt_pkg::UPT_TX_IDLE;
		endcase
	end

	// Header bits are counted in interface clocks, each longer than a full-speed bit
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state <= upt_pkg::UPT_TX_IDLE;
			sof_held <= 1'b0;
			pre_cnt  <= 5'h00;
			eop_cnt  <= 2'h0;
		end else begin
			tx_state <= next_tx_state;
			if ((tx_state == upt_pkg::UPT_TX_IDLE) && tx_cmd) begin
				sof_held <= tx_sof;
			end
			if (next_tx_state == upt_pkg::UPT_TX_PRE_HDR && tx_state != upt_pkg::UPT_TX_PRE_HDR) begin
				pre_cnt <= upt_pkg::PRE_HDR_BITS - 5'h01;
			end else if (next_tx_state == upt_pkg::UPT_TX_PRE_J) begin
				pre_cnt <= upt_pkg::PRE_GAP_BITS - 5'h01;
			end else if (pre_cnt != 5'h00) begin
				pre_cnt <= pre_cnt - 5'h01;
			end
			if (tx_state == upt_pkg::UPT_TX_RESUME) begin
				eop_cnt <= upt_pkg::EOP_SE0_BITS;
			end else if (bit_tick && (eop_cnt != 2'h0)) begin
				eop_cnt <= eop_cnt - 2'h1;
			end
		end
	end

	// ****************************************************
	// Line drive and status
	// ****************************************************
	assign tx_bus_active = (tx_state == upt_pkg::UPT_TX_SEND) || (tx_state == upt_pkg::UPT_TX_END);
	assign pre_header    = (tx_state == upt_pkg::UPT_TX_PRE_HDR);
	assign ls_bit_rate   = (speed == upt_pkg::SPEED_LS) || (is_pre && (tx_state == upt_pkg::UPT_TX_SEND));
	// Bus is released during the gap so the pull-up holds J
	assign drive_oe_n    = !((tx_state == upt_pkg::UPT_TX_PRE_J) || (tx_state == upt_pkg::UPT_TX_RESUME) ||
	                         (tx_state == upt_pkg::UPT_TX_EOP_SE0) || (tx_state == upt_pkg::UPT_TX_EOP_J));
	assign drive_state   = (tx_state == upt_pkg::UPT_TX_RESUME)  ? upt_pkg::LINE_K :
	                       (tx_state == upt_pkg::UPT_TX_EOP_SE0) ? upt_pkg::LINE_SE0 : upt_pkg::LINE_J;
	assign status        = {3'h0, (tx_state == upt_pkg::UPT_TX_EOP_SE0) || (tx_state == upt_pkg::UPT_TX_EOP_J),
	                        tx_bus_active, receive_in_progress, line_sync};

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_rxcmd_jk;
		line_chg && !line_se0 ##1 (!line_chg)[*3] |=> rxcmd_valid;
	endproperty
	a_rxcmd_jk: assert property (p_rxcmd_jk) else $error("J/K receive command not after 4 clocks");

	property p_rxcmd_not_early;
		line_chg |=> (!rxcmd_valid)[*3];
	endproperty
	a_rxcmd_not_early: assert property (p_rxcmd_not_early) else $error("Receive command too early");

	property p_tx_start_hs;
		(tx_state == upt_pkg::UPT_TX_IDLE) && tx_cmd && is_hs && (mode != upt_pkg::MODE_RESUME)
			|=> !tx_bus_active ##1 tx_bus_active;
	endproperty
	a_tx_start_hs: assert property (p_tx_start_hs) else $error("High-speed transmit start not in 2 clocks");

	property p_tx_start_fs;
		(tx_state == upt_pkg::UPT_TX_IDLE) && tx_cmd && (speed == upt_pkg::SPEED_FS) &&
			(mode != upt_pkg::MODE_RESUME) |=> (!tx_bus_active)[*6] ##1 tx_bus_active;
	endproperty
	a_tx_start_fs: assert property (p_tx_start_fs) else $error("Full-speed transmit start not at 7 clocks");

	property p_tx_end_sof;
		(tx_state == upt_pkg::UPT_TX_SEND) && stp && is_hs && sof_held |=> tx_bus_active[*6] ##1 !tx_bus_active;
	endproperty
	a_tx_end_sof: assert property (p_tx_end_sof) else $error("SOF transmit end delay wrong");

	property p_tx_end_pkt;
		(tx_state == upt_pkg::UPT_TX_SEND) && stp && is_hs && !sof_held |=> tx_bus_active[*3] ##1 !tx_bus_active;
	endproperty
	a_tx_end_pkt: assert property (p_tx_end_pkt) else $error("Packet transmit end delay wrong");

	property p_rx_start_hs;
		rx_rise && is_hs && !receive_in_progress ##1 (!rx_fall)[*5] |-> !receive_in_progress ##1 receive_in_progress;
	endproperty
	a_rx_start_hs: assert property (p_rx_start_hs) else $error("High-speed receive start not at 6 clocks");

	property p_pre_gap;
		(tx_state == upt_pkg::UPT_TX_PRE_HDR) && (pre_cnt == 5'h00)
			|=> !drive_oe_n && (drive_state == upt_pkg::LINE_J) ##1 drive_oe_n[*3] ##1 tx_bus_active && ls_bit_rate;
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("Preamble J and gap not as expected");

	property p_pre_header;
		(tx_state == upt_pkg::UPT_TX_START) && tx_done && is_pre |=> pre_header[*8];
	endproperty
	a_pre_header: assert property (p_pre_header) else $error("Preamble header not sent");

	property p_eop;
		(tx_state == upt_pkg::UPT_TX_RESUME) && stp && host_role
			|=> !drive_oe_n && (drive_state == upt_pkg::LINE_SE0) && (eop_cnt == upt_pkg::EOP_SE0_BITS);
	endproperty
	a_eop: assert property (p_eop) else $error("Resume end did not start SE0");

	property p_eop_j;
		(tx_state == upt_pkg::UPT_TX_EOP_SE0) && bit_tick && (eop_cnt == 2'h1)
			|=> !drive_oe_n && (drive_state == upt_pkg::LINE_J);
	endproperty
	a_eop_j: assert property (p_eop_j) else $error("End of resume J missing");

	property p_pre_edges;
		is_pre |-> fs_edge_rate && !(ls_bit_rate && !tx_bus_active);
	endproperty
	a_pre_edges: assert property (p_pre_edges) else $error("Preamble mode not at full-speed edges");

endmodule

// ==== upt_link_model.sv ====
module upt_link_model (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       send,
	input  wire logic       stop,
	input  wire logic       sof,
	input  wire logic [1:0] speed,
	input  wire logic       line_valid,
	input  wire logic [1:0] line_state,
	input  wire logic       rx_active,
	output logic            tx_cmd,
	output logic            tx_sof,
	output logic            stp,
	output logic            ready
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************
	// Link side: commands one cycle after the request
	// ****************************************************
	logic [9:0] gap;
	logic [1:0] last_line;
	logic       rx_active_prev;

	// Response timeout doubles as the back-to-back wait, it is longer than either window
	wire logic [9:0] gap_load = (speed == upt_pkg::SPEED_HS) ? 10'h05c :
		(speed == upt_pkg::SPEED_FS) ? 10'h050 : 10'h2ce;
	// Packet ends restart the wait too, so ready drops and blocks a packet one clock later
	wire logic rx_end = !rx_active && rx_active_prev && (speed == upt_pkg::SPEED_HS);
	wire logic se0_to_j = line_valid && (line_state == upt_pkg::LINE_J) && (last_line == upt_pkg::LINE_SE0) &&
		(speed != upt_pkg::SPEED_HS);
	wire logic [9:0] next_gap = (stop || rx_end || se0_to_j) ? gap_load :
		((gap != 10'h000) ? gap - 10'h001 : gap);

	assign ready = (gap == 10'h000);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_cmd <= 1'b0;
			tx_sof <= 1'b0;
			stp    <= 1'b0;
			gap    <= 10'h000;
			last_line      <= upt_pkg::LINE_J;
			rx_active_prev <= 1'b0;
		end else begin
			last_line      <= line_valid ? line_state : last_line;
			rx_active_prev <= rx_active;
			tx_cmd <= send & ready;
			tx_sof <= send & sof;
			stp    <= stop;
			gap    <= next_gap;
		end
	end
endmodule

// ==== tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************
	// Stimulus and wiring
	// ****************************************************
	logic       core_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       rx_sync_raw = 1'b0;
	logic [1:0] line_state_raw = 2'h1;
	logic       ls_bit_clk = 1'b0;
	logic       send = 1'b0;
	logic       stop = 1'b0;
	logic       sof = 1'b0;
	wire logic [7:0] reg_rdata;
	wire logic [1:0] rxcmd_line_state, drive_state, speed_select_field;
	wire logic tx_cmd, tx_sof, stp, ready, rxcmd_valid, receive_in_progress, tx_bus_active;
	wire logic pre_header, ls_bit_rate, fs_edge_rate, drive_oe_n, termination_select_bit, active_low_low_power_bit;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         seed = 50988;
	int         k;
	logic [7:0] d;
	logic [7:0] r;
	logic [1:0] spd [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
	logic [1:0] lns [4] = '{2'h2, 2'h1, 2'h0, 2'h1};
	int         nrx [4] = '{4, 4, 16, 4};
	logic [1:0] rsp [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	int         rst_d [4] = '{8, 4, 4, 4};
	int         ren_d [4] = '{8, 20, 125, 125};
	logic [1:0] tsp [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
	logic       tsf [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int         tst [4] = '{1, 1, 6, 74};
	int         ten [4] = '{3, 6, 0, 0};

	always #50 core_clk = ~core_clk;
	// Low-speed bit clock runs free, phase unrelated to the core clock
	initial #37 forever #400 ls_bit_clk = ~ls_bit_clk;

	upt_timing dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_cmd(tx_cmd), .tx_sof(tx_sof),
		.stp(stp), .rx_sync_raw(rx_sync_raw), .line_state_raw(line_state_raw), .ls_bit_clk(ls_bit_clk),
		.rxcmd_valid(rxcmd_valid), .rxcmd_line_state(rxcmd_line_state),
		.receive_in_progress(receive_in_progress), .tx_bus_active(tx_bus_active), .pre_header(pre_header),
		.ls_bit_rate(ls_bit_rate), .fs_edge_rate(fs_edge_rate), .drive_state(drive_state),
		.drive_oe_n(drive_oe_n), .speed_select_field(speed_select_field),
		.termination_select_bit(termination_select_bit), .active_low_low_power_bit(active_low_low_power_bit));

	upt_link_model link_u (.core_clk(core_clk), .arst_n(arst_n), .send(send), .stop(stop), .sof(sof),
		.speed(speed_select_field), .line_valid(rxcmd_valid), .line_state(rxcmd_line_state),
		.rx_active(receive_in_progress), .tx_cmd(tx_cmd), .tx_sof(tx_sof), .stp(stp), .ready(ready));

	// ****************************************************
	// Checking and bus tasks
	// ****************************************************
	task automatic end_of_test;
		$display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic pulse(input logic is_stop, input logic is_sof);
		@(posedge core_clk);
		send <= ~is_stop;
		stop <= is_stop;
		sof <= is_sof;
		@(posedge core_clk);
		send <= 1'b0;
		stop <= 1'b0;
		@(posedge core_clk);
	endtask

	function automatic logic sig(input int sel);
		case (sel)
			0: sig = rxcmd_valid;
			1: sig = receive_in_progress;
			2: sig = tx_bus_active;
			3: sig = pre_header;
			4: sig = drive_oe_n;
			5: sig = ready;
			default: sig = (drive_state === upt_pkg::LINE_SE0);
		endcase
	endfunction

	// Counts settled cycles until the watched output reaches the level; a hang ends the run
	task automatic wait_lvl(input int sel, input logic lvl, output int n);
		n = 0;
		#1;
		while (sig(sel) !== lvl && n < 1000) begin
			@(posedge core_clk);
			#1 n++;
		end
		if (n >= 1000) begin
			miscompares++;
			end_of_test();
		end
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1 chk({drive_oe_n, fs_edge_rate, ls_bit_rate, tx_bus_active, speed_select_field, rxcmd_line_state},
			8'h c5);
		rd(4'h0, r);
		chk(r, 8'h31);
		wr(4'h4, 8'hff);
		rd(4'h4, r);
		chk(r, 8'h01);
		rd(4'h8, r);
		chk(r, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			wr(4'h0, d);
			rd(4'h0, r);
			chk(r, d);
			chk({4'h0, speed_select_field, termination_select_bit, active_low_low_power_bit},
				{4'h0, d[1:0], d[4], d[5]});
		end
		wr(4'h0, 8'h31);
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {6'b001100, spd[i]});
			repeat (25) @(posedge core_clk);
			line_state_raw <= lns[i];
			wait_lvl(0, 1'b1, k);
			chk_n(k, 2 + nrx[i]);
			chk({6'h0, rxcmd_line_state}, {6'h0, lns[i]});
		end
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {6'b001100, rsp[i]});
			@(posedge core_clk);
			rx_sync_raw <= 1'b1;
			wait_lvl(1, 1'b1, k);
			chk_n(k, rst_d[i]);
			@(posedge core_clk);
			rx_sync_raw <= 1'b0;
			wait_lvl(1, 1'b0, k);
			chk_n(k, ren_d[i]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {6'b001100, tsp[i]});
			wait_lvl(5, 1'b1, k);
			pulse(1'b0, tsf[i]);
			wait_lvl(2, 1'b1, k);
			chk_n(k, tst[i]);
			pulse(1'b1, 1'b0);
			wait_lvl(2, 1'b0, k);
			chk_n(k, ten[i]);
		end
		wr(4'h0, 8'h33);
		wait_lvl(5, 1'b1, k);
		pulse(1'b0, 1'b0);
		wait_lvl(3, 1'b1, k);
		chk_n(k, 6);
		wait_lvl(3, 1'b0, k);
		chk_n(k, 16);
		chk({5'h0, drive_oe_n, drive_state}, 8'h01);
		wait_lvl(2, 1'b1, k);
		chk_n(k, 4);
		chk({6'h0, ls_bit_rate, fs_edge_rate}, 8'h03);
		pulse(1'b1, 1'b0);
		wait_lvl(2, 1'b0, k);
		wr(4'h0, 8'hf9);
		wait_lvl(5, 1'b1, k);
		pulse(1'b0, 1'b0);
		wait_lvl(4, 1'b0, k);
		chk({6'h0, drive_state}, 8'h02);
		repeat (20) @(posedge core_clk);
		pulse(1'b1, 1'b0);
		wait_lvl(6, 1'b1, k);
		chk_n(k, 0);
		wait_lvl(6, 1'b0, k);
		// Two ticks of an unrelated bit clock plus the sync flops span eight to eighteen cycles
		chk({7'h0, (k >= 8 && k <= 18)}, 8'h01);
		chk({5'h0, drive_oe_n, drive_state}, 8'h01);
		rd(4'h4, r);
		chk(r, 8'h11);
		wait_lvl(4, 1'b1, k);
		chk({7'h0, (k >= 1 && k <= 12)}, 8'h01);
		wr(4'h0, 8'h31);
		wr(4'h0, 8'h11);
		#1 chk({7'h0, active_low_low_power_bit}, 8'h00);
		end_of_test();
	end
endmodule
